//--- psesr_checker.sv
/* psesr_checker: assertions on the register port of psesr_top.
   assumes one clock with a synchronous active-high reset; bound below. */
module psesr_checker #(
  parameter int CHANNELS = 8
) (
  input wire logic                i_mclk,
  input wire logic                i_srst,
  input wire logic [CHANNELS-1:0] i_attached,
  input wire logic [CHANNELS-1:0] i_hispeed,
  input wire logic [CHANNELS-1:0] i_overcur,
  input wire logic [31:0]         i_temp_micro_c,
  input wire logic [3:0]          i_addr,
  input wire logic                i_wr,
  input wire logic                i_rd,
  input wire logic [31:0]         o_rdata
);
  // ==========================================================
  // read answers, one cycle after the strobe
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);
  idle_zero_a: assert property (
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  temp_read_a: assert property (
    i_rd && i_addr == psesr_pkg::OFS_TEMP |=> o_rdata == $past(i_temp_micro_c))
    else $error("temperature word mismatch");
  unmapped_zero_a: assert property (
    i_rd && i_addr > psesr_pkg::OFS_TEMP |=> o_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  state_rsvd_a: assert property (
    i_rd && i_addr < 4'h2 |=> (o_rdata & 32'hC6C6_C6C6) == 32'h0000_0000)
    else $error("state reserved bit set");
  error_rsvd_a: assert property (
    i_rd && i_addr[3:1] == 3'h1 |=> (o_rdata & 32'hFEFE_FEFE) == 32'h0000_0000)
    else $error("error reserved bit set");
  // sync depth plus flag leaves three edges; four gives margin
  err_low_a: assert property (
    (i_overcur[0] && !i_wr) [*4] ##1 (i_rd && i_addr == psesr_pkg::OFS_ERROR_LOW)
    |=> o_rdata[0]) else $error("channel zero overcurrent missing");
  err_high_a: assert property (
    (i_overcur[6] && !i_wr) [*4] ##1 (i_rd && i_addr == psesr_pkg::OFS_ERROR_HIGH)
    |=> o_rdata[16]) else $error("channel six overcurrent missing");
  attach_lane_a: assert property (
    i_attached[7] [*4] ##1 (i_rd && i_addr == psesr_pkg::OFS_STATE_HIGH)
    |=> o_rdata[24]) else $error("channel seven attach missing");
  hispeed_lane_a: assert property (
    i_hispeed[2] [*4] ##1 (i_rd && i_addr == psesr_pkg::OFS_STATE_LOW)
    |=> o_rdata[20]) else $error("channel two hispeed missing");
endmodule // psesr_checker

bind psesr_top psesr_checker #(.CHANNELS(CHANNELS)) i_chk (.i_mclk, .i_srst, .i_attached,
  .i_hispeed, .i_overcur, .i_temp_micro_c, .i_addr, .i_wr, .i_rd, .o_rdata);

//--- psesr_lane.sv
/*
  One channel: sticky overcurrent flag with per-channel clear.
  Assumes synchronised overcurrent level and a one-cycle clear pulse.
*/
module psesr_lane (
  input  wire logic i_mclk,
  input  wire logic i_srst,
  input  wire logic i_overcur,
  input  wire logic i_clear,
  output logic      o_err
);
  // sticky until clear; a fresh event beats the clear
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_err <= 1'b0;
    end else if (i_overcur) begin
      o_err <= 1'b1;
    end else if (i_clear) begin
      o_err <= 1'b0;
    end
  end
endmodule // psesr_lane

//--- psesr_pkg.sv
/*
  Package for the port state and error status block: register offsets,
  lane layout, reset values and the structs that carry port status and register requests.
  Assumes a single 20 MHz clock and a plain register port.
*/
// Behaviour
// - two port state words, bank zero and bank one
// - lane bit zero flags an attached device
// - lane bit three flags a recorded error
// - lane bit four flags Hi-Speed operation
// - lane bit five flags SuperSpeed operation
// - lanes sit at bits 0, 8, 16, 24
// - two error words, bank zero and one
// - bank zero error bits 0, 8, 16, 24 for channels zero-three
// - bank one error lanes serve channels four-seven
// - clear command acts per channel, independently
// - clear resets state error and error bits
// - temperature returned in micro-degrees Celsius
package psesr_pkg;
  // ==========================================================
  // register map (word offsets)
  localparam logic [3:0] OFS_STATE_LOW  = 4'h0;
  localparam logic [3:0] OFS_STATE_HIGH = 4'h1;
  localparam logic [3:0] OFS_ERROR_LOW  = 4'h2;
  localparam logic [3:0] OFS_ERROR_HIGH = 4'h3;
  localparam logic [3:0] OFS_TEMP       = 4'h4;
  localparam logic [3:0] OFS_CLEAR      = 4'h5;

  // ==========================================================
  // lane layout
  localparam int LANE_W      = 8;
  localparam int BIT_ATTACH  = 0;
  localparam int BIT_ERROR   = 3;
  localparam int BIT_HISPEED = 4;
  localparam int BIT_SUPER   = 5;
  localparam int BIT_OVERCUR = 0;
  localparam int CH_PER_BANK = 4;

  // ==========================================================
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0]  RST_ERR  = 8'h00;

  typedef struct packed {
    logic attached;
    logic hispeed;
    logic superspeed;
  } psesr_port_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } psesr_req_t;
endpackage

//--- psesr_sync.sv
/*
  Two-flop synchroniser for a vector of pin levels.
  Assumes inputs asynchronous to i_mclk.
*/
module psesr_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_mclk,
  input  wire logic             i_srst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule // psesr_sync

//--- psesr_top.sv
/*
  Port state and error status register bank for an eight-channel hub.
  Channel status pins are asynchronous and are synchronised here;
  the temperature word comes from logic on the same clock.
  Assumes a register master that keeps the strobe protocol.
*/
module psesr_top #(
  parameter int CHANNELS = 8
) (
  input  wire logic                i_mclk,
  input  wire logic                i_srst,
  input  wire logic [CHANNELS-1:0] i_attached,
  input  wire logic [CHANNELS-1:0] i_hispeed,
  input  wire logic [CHANNELS-1:0] i_superspeed,
  input  wire logic [CHANNELS-1:0] i_overcur,
  input  wire logic [31:0]         i_temp_micro_c,
  input  wire logic [3:0]          i_addr,
  input  wire logic [31:0]         i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output logic      [31:0]         o_rdata
);
  // ==========================================================
  // synchronised pins
  logic [CHANNELS-1:0] att_s;
  logic [CHANNELS-1:0] hs_s;
  logic [CHANNELS-1:0] ss_s;
  logic [CHANNELS-1:0] oc_s;
  logic [CHANNELS-1:0] clr;
  logic [CHANNELS-1:0] err;
  psesr_pkg::psesr_port_t port [CHANNELS];
  psesr_pkg::psesr_req_t  req;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  psesr_sync #(.WIDTH(4*CHANNELS)) u_sync (
    .i_mclk  (i_mclk),
    .i_srst  (i_srst),
    .i_async ({i_attached, i_hispeed, i_superspeed, i_overcur}),
    .o_sync  ({att_s, hs_s, ss_s, oc_s})
  );

  // ==========================================================
  // clear command: write a channel mask to the clear offset
  // each set bit clears only its own channel
  always_comb begin
    if (req.wr && req.addr == psesr_pkg::OFS_CLEAR) begin
      clr = req.wdata[CHANNELS-1:0];
    end else begin
      clr = '0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      assign port[g] = '{attached: att_s[g], hispeed: hs_s[g], superspeed: ss_s[g]};
      psesr_lane u_lane (
        .i_mclk    (i_mclk),
        .i_srst    (i_srst),
        .i_overcur (oc_s[g]),
        .i_clear   (clr[g]),
        .o_err     (err[g])
      );
    end
  endgenerate

  // ==========================================================
  // word packing
  // bank selects channels 0-3 or 4-7
  function automatic logic [31:0] state_word(input int bank);
    logic [31:0] w;
    int          ch;
    w = psesr_pkg::RST_WORD;
    for (int l = 0; l < psesr_pkg::CH_PER_BANK; l++) begin
      ch = bank * psesr_pkg::CH_PER_BANK + l;
      // lane base at l*8; attach bit
      w[l*psesr_pkg::LANE_W + psesr_pkg::BIT_ATTACH]  = port[ch].attached;
      w[l*psesr_pkg::LANE_W + psesr_pkg::BIT_ERROR]   = err[ch];
      w[l*psesr_pkg::LANE_W + psesr_pkg::BIT_HISPEED] = port[ch].hispeed;
      w[l*psesr_pkg::LANE_W + psesr_pkg::BIT_SUPER]   = port[ch].superspeed;
    end
    return w;
  endfunction

  // error words, bank 0 or 1 only
  function automatic logic [31:0] error_word(input int bank);
    logic [31:0] w;
    w = psesr_pkg::RST_WORD;
    for (int l = 0; l < psesr_pkg::CH_PER_BANK; l++) begin
      w[l*psesr_pkg::LANE_W + psesr_pkg::BIT_OVERCUR] =
        err[bank*psesr_pkg::CH_PER_BANK + l];
    end
    return w;
  endfunction

  // ==========================================================
  // read port: data the cycle after the strobe, zero otherwise
  always_ff @(posedge i_mclk) begin
    if (i_srst || !req.rd) begin
      o_rdata <= psesr_pkg::RST_WORD;
    end else begin
      case (req.addr)
        psesr_pkg::OFS_STATE_LOW:  o_rdata <= state_word(0);
        psesr_pkg::OFS_STATE_HIGH: o_rdata <= state_word(1);
        psesr_pkg::OFS_ERROR_LOW:  o_rdata <= error_word(0);
        psesr_pkg::OFS_ERROR_HIGH: o_rdata <= error_word(1);
        psesr_pkg::OFS_TEMP:       o_rdata <= i_temp_micro_c;
        default:                   o_rdata <= psesr_pkg::RST_WORD;
      endcase
    end
  end
endmodule // psesr_top

//--- tb_top.sv
/* tb_top: register-port bench for psesr_top.
   assumes the 20 MHz clock and four cycles of synchronous reset. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_mclk = 1'b0;
  logic        i_srst = 1'b1;
  logic [7:0]  i_attached = 8'h00, i_hispeed = 8'h00, i_superspeed = 8'h00, i_overcur = 8'h00;
  logic [31:0] i_temp_micro_c = 32'h0000_0000, i_wdata = 32'h0000_0000, o_rdata;
  logic [3:0]  i_addr = 4'h0;
  logic        i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0]  er = 8'h00;
  int          fail_count = 0, checked = 0;
  always #25 i_mclk = ~i_mclk;
  psesr_top i_dut (.i_mclk, .i_srst, .i_attached, .i_hispeed, .i_superspeed, .i_overcur,
    .i_temp_micro_c, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata);
  // expected word: state lanes or error lanes of a bank
  function automatic logic [31:0] sw(input int b, input bit st);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int c = 0; c < 4; c++) begin
      w[8*c] = st ? i_attached[4*b+c] : er[4*b+c];
      if (st) w[8*c+3 +: 3] = {i_superspeed[4*b+c], i_hispeed[4*b+c], er[4*b+c]};
    end
    return w;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    checked++;
    if (o_rdata !== e) begin
      fail_count++;
      $display("[ERR] word %0h exp %h got %h", a, e, o_rdata);
    end
    @(posedge i_mclk);
  endtask
  task automatic sall();
    rd(4'h0, sw(0, 1));
    rd(4'h1, sw(1, 1));
    rd(4'h2, sw(0, 0));
    rd(4'h3, sw(1, 0));
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #300000;
    fail_count++;
    test_done;
  end
  initial begin
    repeat (4) @(posedge i_mclk);
    i_srst <= 1'b0;
    for (int a = 0; a < 16; a++) rd(4'(a), 32'h0000_0000);
    i_attached <= 8'hA5;
    i_hispeed <= 8'h3C;
    i_superspeed <= 8'hC3;
    i_temp_micro_c <= 32'hFFF0_BDC0;
    repeat (4) @(posedge i_mclk);
    sall();
    rd(4'h4, 32'hFFF0_BDC0);
    i_overcur <= 8'h41;
    er = 8'h41;
    repeat (4) @(posedge i_mclk);
    rd(4'h2, sw(0, 0));
    rd(4'h3, sw(1, 0));
    i_overcur <= 8'h00;
    repeat (4) @(posedge i_mclk);
    sall();
    // error words are read-only: writing them must not clear
    wr(4'h2, 32'hFFFF_FFFF);
    sall();
    wr(4'h5, 32'h0000_0001);
    er = 8'h40;
    sall();
    i_overcur <= 8'h80;
    er = 8'hC0;
    repeat (4) @(posedge i_mclk);
    wr(4'h5, 32'h0000_0080);
    sall();
    i_overcur <= 8'h00;
    repeat (4) @(posedge i_mclk);
    wr(4'h5, 32'h0000_00FF);
    er = 8'h00;
    sall();
    test_done;
  end
endmodule // tb_top
